// ==== rtl/video_cfg_pkg.sv ====
// constants and types shared by the video configuration block
package video_cfg_pkg;
  localparam logic [7:0]  OP_CONTROL_SECOND = 8'h2D;
  localparam logic [7:0]  OP_V_TABLE        = 8'h2E;
  localparam logic [7:0]  OP_U_TABLE        = 8'h2F;
  localparam logic [7:0]  OP_PROGRAM        = 8'h30;
  localparam logic [5:0]  SHORT_FRAME_BITS  = 6'h18;
  localparam logic [5:0]  LONG_FRAME_BITS   = 6'h28;
  localparam logic [5:0]  MAX_FRAME_BITS    = 6'h28;
  localparam int          ENABLE_BIT        = 15;
  localparam int          STANDARD_BIT      = 14;
  localparam int          RUN_LEN_HI        = 13;
  localparam int          RUN_LEN_LO        = 10;
  localparam int          LINES_HI          = 9;
  localparam int          LINES_LO          = 0;
  localparam int          CODE_HI           = 7;
  localparam int          CODE_LO           = 6;
  localparam int          AMOUNT_HI         = 5;
  localparam int          AMOUNT_LO         = 3;
  localparam int          SHIFT_HI          = 2;
  localparam int          SHIFT_LO          = 0;
  localparam int          ENTRY_BITS        = 4;
  localparam int          CMD_BITS          = 8;
  localparam logic [15:0] CONTROL_RESET     = 16'h0000;
  localparam logic [15:0] TABLE_RESET       = 16'h0000;
  localparam logic [31:0] PROGRAM_RESET     = 32'h0000_0000;
  localparam logic [3:0]  PROTO_RUN_LAST    = 4'h7;
  localparam logic [3:0]  PROGRAM_STEPS     = 4'h4;
  localparam logic [7:0]  FULL_MASK         = 8'hFF;
  localparam logic [2:0]  MAX_AMOUNT_FIELD  = 3'h7;
  localparam longint      CLK_HZ            = 50_000_000;
  localparam longint      NTSC_SUB_HZ       = 3_579_545;
  localparam longint      PAL_SUB_HZ        = 4_433_618;
  localparam int          PHASE_W           = 32;
  localparam logic [31:0] NTSC_STEP         = 32'((NTSC_SUB_HZ << PHASE_W) / CLK_HZ);
  localparam logic [31:0] PAL_STEP          = 32'((PAL_SUB_HZ << PHASE_W) / CLK_HZ);
  typedef enum logic [1:0] {
    PICK_V    = 2'h0,
    PICK_U    = 2'h1,
    PICK_Y    = 2'h2,
    PICK_NONE = 2'h3
  } pick_code_t;
  typedef enum logic [2:0] {
    SPI_IDLE  = 3'h1,
    SPI_SHIFT = 3'h2,
    SPI_HOLD  = 3'h4
  } spi_state_t;
  typedef struct packed {
    logic [7:0]  opcode;
    logic [31:0] data;
  } cfg_write_t;
endpackage

// ==== rtl/cfg_stream_if.sv ====
// valid/ready carrier for committed register writes
`timescale 1ns/1ps
interface cfg_stream_if;
  video_cfg_pkg::cfg_write_t data;
  logic                      valid;
  logic                      ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface

// ==== rtl/cfg_write_buffer.sv ====
// two-entry buffer for committed register writes
`timescale 1ns/1ps
module cfg_write_buffer (
  input  wire logic         clk,
  input  wire logic         rstn,
  cfg_stream_if.sink        fill,
  cfg_stream_if.source      drain
);
  import video_cfg_pkg::*;

  cfg_write_t entry [2];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  logic       push;
  logic       pop;

  assign fill.ready  = (count != 2'h2);
  assign drain.valid = (count != 2'h0);
  assign drain.data  = entry[rd_ptr];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      entry[0] <= '0;
      entry[1] <= '0;
    end else if (push) begin
      entry[wr_ptr] <= fill.data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule

// ==== rtl/video_generator_config_regs.sv ====
// serial-loaded video configuration registers and microcode engine
// Notes on behaviour
// - opcode 2Dh loads control word on release
// - bit 15 enables generator, reset off
// - bit 14 selects PAL, negating V alternately
// - subcarrier 3.579545 or 4.433618 MHz by standard
// - run lasts field plus one cycles
// - protolines always run eight cycles
// - line total is field plus one
// - after last line restart index fetch
// - opcode 2Eh loads V table on release
// - V table four nibbles, entry three high
// - two V bits choose table entry
// - opcode 2Fh loads U table on release
// - U table laid out like V table
// - opcode 30h loads 32-bit program on release
// - program cycle n uses byte n
// - top two bits choose V, U, Y, none
// - translation selects table, Y always from data
// - amount taken is field plus one bits
// - data shifts by zero to seven bits
// - translate input selects table for U and V
`timescale 1ns/1ps
module video_generator_config_regs (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        sclk,
  input  wire logic        select_line_n,
  input  wire logic        mosi,
  input  wire logic        chroma_translate,
  input  wire logic        protoline,
  input  wire logic        line_done,
  input  wire logic [15:0] sram_word,
  output logic             video_enabled,
  output logic             video_standard_sel,
  output logic             subcarrier_clock,
  output logic             index_restart,
  output logic [9:0]       current_line,
  output logic [7:0]       y_value,
  output logic [5:0]       u_value,
  output logic [5:0]       v_value
);
  import video_cfg_pkg::*;

  cfg_stream_if to_buffer ();
  cfg_stream_if from_buffer ();

  cfg_write_buffer u_buffer (
    .clk   (clk),
    .rstn  (rstn),
    .fill  (to_buffer.sink),
    .drain (from_buffer.source)
  );

  // pin sampling, three stages each
  logic [2:0] sclk_s;
  logic [2:0] sel_s;
  logic [2:0] mosi_s;
  logic       sclk_q;
  logic       sel_n_q;
  logic       sclk_rise;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_s <= 3'h0;
      sel_s  <= 3'h7;
      mosi_s <= 3'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk};
      sel_s  <= {sel_s[1:0], select_line_n};
      mosi_s <= {mosi_s[1:0], mosi};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q  <= 1'b0;
      sel_n_q <= 1'b1;
    end else begin
      if (sclk_s[1] == sclk_s[2]) sclk_q <= sclk_s[2];
      if (sel_s[1] == sel_s[2]) sel_n_q <= sel_s[2];
    end
  end

  assign sclk_rise = (sclk_s[1] == sclk_s[2]) && sclk_s[2] && !sclk_q && !sel_n_q;

  // serial frame capture
  spi_state_t  state;
  logic [39:0] shift_in;
  logic [5:0]  bit_count;
  cfg_write_t  pending;
  logic        frame_ok;
  cfg_write_t  framed;

  always_comb begin
    framed   = '0;
    frame_ok = 1'b0;
    if (bit_count == SHORT_FRAME_BITS) begin
      framed.opcode = shift_in[23:16];
      framed.data   = {16'h0000, shift_in[15:0]};
      frame_ok      = (framed.opcode == OP_CONTROL_SECOND) || (framed.opcode == OP_V_TABLE) ||
                      (framed.opcode == OP_U_TABLE);
    end else if (bit_count == LONG_FRAME_BITS) begin
      framed.opcode = shift_in[39:32];
      framed.data   = shift_in[31:0];
      frame_ok      = (framed.opcode == OP_PROGRAM);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state     <= SPI_IDLE;
      shift_in  <= '0;
      bit_count <= 6'h0;
      pending   <= '0;
    end else begin
      case (state)
        SPI_IDLE: begin
          bit_count <= 6'h0;
          if (!sel_n_q) state <= SPI_SHIFT;
        end
        SPI_SHIFT: begin
          if (sel_n_q) begin
            pending <= framed;
            state   <= frame_ok ? SPI_HOLD : SPI_IDLE;
          end else if (sclk_rise) begin
            shift_in <= {shift_in[38:0], mosi_s[2]};
            // count one past the longest frame so overlong frames are dropped
            if (bit_count <= MAX_FRAME_BITS) bit_count <= 6'(bit_count + 6'h1);
          end
        end
        SPI_HOLD: begin
          if (to_buffer.ready) state <= SPI_IDLE;
        end
        default: state <= SPI_IDLE;
      endcase
    end
  end

  assign to_buffer.valid = (state == SPI_HOLD);
  assign to_buffer.data  = pending;

  // configuration registers
  logic [15:0] video_control_second;
  logic [15:0] v_translate_table;
  logic [15:0] u_translate_table;
  logic [31:0] microcode_program;
  logic [3:0]  run_length;
  logic [9:0]  frame_line_total;
  logic [3:0]  run_cycle;
  logic [3:0]  run_last;
  logic        run_end;
  logic        apply;

  assign run_length       = video_control_second[RUN_LEN_HI:RUN_LEN_LO];
  assign frame_line_total = video_control_second[LINES_HI:LINES_LO];
  assign video_enabled      = video_control_second[ENABLE_BIT];
  assign video_standard_sel = video_control_second[STANDARD_BIT];
  assign run_last = protoline ? PROTO_RUN_LAST : run_length;
  // protoline dropping mid-run ends the run at once instead of wrapping the counter
  assign run_end  = (run_cycle >= run_last);
  // writes land only between runs so a run never sees a half-changed program
  assign from_buffer.ready = !video_enabled || run_end;
  assign apply = from_buffer.valid && from_buffer.ready;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      video_control_second <= CONTROL_RESET;
      v_translate_table    <= TABLE_RESET;
      u_translate_table    <= TABLE_RESET;
      microcode_program    <= PROGRAM_RESET;
    end else if (apply) begin
      case (from_buffer.data.opcode)
        OP_CONTROL_SECOND: video_control_second <= from_buffer.data.data[15:0];
        OP_V_TABLE:        v_translate_table    <= from_buffer.data.data[15:0];
        OP_U_TABLE:        u_translate_table    <= from_buffer.data.data[15:0];
        OP_PROGRAM:        microcode_program    <= from_buffer.data.data;
        default:           microcode_program    <= microcode_program;
      endcase
    end
  end

  // microcode run sequencing
  logic [7:0]  cmd;
  logic        exec;
  pick_code_t  cmd_code;
  logic [2:0]  cmd_shift;
  logic [7:0]  pick_mask;
  logic [7:0]  picked;
  logic [15:0] window;
  logic [1:0]  entry_sel;
  logic [3:0]  v_entry;
  logic [3:0]  u_entry;
  logic [5:0]  v_raw;
  logic        pal_line;

  assign exec      = video_enabled && (run_cycle < PROGRAM_STEPS);
  assign cmd       = microcode_program[CMD_BITS * run_cycle[1:0] +: CMD_BITS];
  assign cmd_code  = pick_code_t'(cmd[CODE_HI:CODE_LO]);
  assign cmd_shift = cmd[SHIFT_HI:SHIFT_LO];
  assign pick_mask = FULL_MASK >> (MAX_AMOUNT_FIELD - cmd[AMOUNT_HI:AMOUNT_LO]);
  assign picked    = window[7:0] & pick_mask;
  assign entry_sel = window[1:0];
  assign v_entry   = v_translate_table[ENTRY_BITS * entry_sel +: ENTRY_BITS];
  assign u_entry   = u_translate_table[ENTRY_BITS * entry_sel +: ENTRY_BITS];
  assign v_raw     = chroma_translate ? {2'h0, v_entry} : picked[5:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_cycle <= 4'h0;
    end else if (!video_enabled || run_end) begin
      run_cycle <= 4'h0;
    end else begin
      run_cycle <= 4'(run_cycle + 4'h1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      window <= 16'h0000;
    end else if (!video_enabled || run_end) begin
      window <= sram_word;
    end else if (exec) begin
      window <= window >> cmd_shift;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      y_value <= 8'h00;
      u_value <= 6'h00;
      v_value <= 6'h00;
    end else if (exec) begin
      case (cmd_code)
        PICK_V:  v_value <= (video_standard_sel && pal_line) ? 6'(-v_raw) : v_raw;
        PICK_U:  u_value <= chroma_translate ? {2'h0, u_entry} : picked[5:0];
        PICK_Y:  y_value <= picked;
        default: y_value <= y_value;
      endcase
    end
  end

  // line counting and index restart
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      current_line  <= 10'h000;
      index_restart <= 1'b0;
      pal_line      <= 1'b0;
    end else if (!video_enabled) begin
      current_line  <= 10'h000;
      index_restart <= 1'b0;
      pal_line      <= 1'b0;
    end else begin
      index_restart <= 1'b0;
      if (line_done) begin
        pal_line <= ~pal_line;
        if (current_line == frame_line_total) begin
          current_line  <= 10'h000;
          index_restart <= 1'b1;
        end else begin
          current_line <= 10'(current_line + 10'h001);
        end
      end
    end
  end

  // subcarrier phase accumulator
  logic [31:0] phase;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase            <= 32'h0000_0000;
      subcarrier_clock <= 1'b0;
    end else if (!video_enabled) begin
      phase            <= 32'h0000_0000;
      subcarrier_clock <= 1'b0;
    end else begin
      phase            <= 32'(phase + (video_standard_sel ? PAL_STEP : NTSC_STEP));
      subcarrier_clock <= phase[PHASE_W-1];
    end
  end

  // checks
  property p_control_commit;
    @(posedge clk) disable iff (!rstn)
    apply && from_buffer.data.opcode == OP_CONTROL_SECOND |=>
      video_enabled == $past(from_buffer.data.data[ENABLE_BIT]) &&
      video_standard_sel == $past(from_buffer.data.data[STANDARD_BIT]);
  endproperty
  a_control_commit: assert property (p_control_commit) else $error("control word not committed");

  property p_program_commit;
    @(posedge clk) disable iff (!rstn)
    apply && from_buffer.data.opcode == OP_PROGRAM |=> microcode_program == $past(from_buffer.data.data);
  endproperty
  a_program_commit: assert property (p_program_commit) else $error("program not committed");

  property p_table_commit;
    @(posedge clk) disable iff (!rstn)
    apply && from_buffer.data.opcode == OP_V_TABLE |=> v_translate_table == $past(from_buffer.data.data[15:0]);
  endproperty
  a_table_commit: assert property (p_table_commit) else $error("V table not committed");

  property p_release_commit;
    @(posedge clk) disable iff (!rstn)
    state == SPI_SHIFT && sel_n_q && frame_ok |=> to_buffer.valid;
  endproperty
  a_release_commit: assert property (p_release_commit) else $error("release did not offer write");

  property p_run_wrap;
    @(posedge clk) disable iff (!rstn)
    video_enabled && !protoline && run_cycle == run_length |=> run_cycle == 4'h0;
  endproperty
  a_run_wrap: assert property (p_run_wrap) else $error("run length wrong");

  property p_proto_run;
    @(posedge clk) disable iff (!rstn)
    video_enabled && protoline && run_cycle == PROTO_RUN_LAST |=> run_cycle == 4'h0;
  endproperty
  a_proto_run: assert property (p_proto_run) else $error("protoline run not eight cycles");

  property p_frame_wrap;
    @(posedge clk) disable iff (!rstn)
    video_enabled && line_done && current_line == frame_line_total |=> current_line == 10'h000 && index_restart;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not restart");

  property p_shift_window;
    @(posedge clk) disable iff (!rstn)
    exec && !run_end |=> window == ($past(window) >> $past(cmd_shift));
  endproperty
  a_shift_window: assert property (p_shift_window) else $error("data shift wrong");

  property p_v_translate;
    @(posedge clk) disable iff (!rstn)
    exec && cmd_code == PICK_V && chroma_translate && !video_standard_sel |=> v_value == {2'h0, $past(v_entry)};
  endproperty
  a_v_translate: assert property (p_v_translate) else $error("V table entry not chosen");

  property p_subcarrier_step;
    @(posedge clk) disable iff (!rstn)
    video_enabled && $past(video_enabled) && !video_standard_sel && $stable(video_control_second) |->
      phase == 32'($past(phase) + NTSC_STEP);
  endproperty
  a_subcarrier_step: assert property (p_subcarrier_step) else $error("subcarrier step wrong");

  c_program_write: cover property (@(posedge clk) disable iff (!rstn) apply && from_buffer.data.opcode == OP_PROGRAM);
  c_buffer_stall: cover property (@(posedge clk) disable iff (!rstn) to_buffer.valid && !to_buffer.ready);
  c_frame_restart: cover property (@(posedge clk) disable iff (!rstn) index_restart);
endmodule

// ==== testbench/spi_host_model.sv ====
// serial host model that loads the write-only video registers
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk,
  output logic select_line_n,
  output logic mosi
);
  initial begin
    sclk          = 1'b0;
    select_line_n = 1'b1;
    mosi          = 1'b0;
  end
  // select low, opcode then data msb first, clock idles low, commit on release
  task automatic send(input logic [39:0] frame, input int nbits);
    select_line_n <= 1'b0;
    #80;
    for (int i = 0; i < nbits; i++) begin
      mosi <= frame[39 - i];
      #40;
      sclk <= 1'b1;
      #80;
      sclk <= 1'b0;
      #40;
    end
    select_line_n <= 1'b1;
    // released data line does not keep its last level
    mosi          <= ~mosi;
  endtask
endmodule

// ==== testbench/video_generator_config_regs_tb_top.sv ====
// testbench for the video configuration registers
`timescale 1ns/1ps
module video_generator_config_regs_tb_top;
  import video_cfg_pkg::*;
  logic        clk;
  logic        rstn;
  logic        sclk;
  logic        select_line_n;
  logic        mosi;
  logic        chroma_translate;
  logic        protoline;
  logic        line_done;
  logic [15:0] sram_word;
  logic        video_enabled;
  logic        video_standard_sel;
  logic        subcarrier_clock;
  logic        index_restart;
  logic [9:0]  current_line;
  logic [7:0]  y_value;
  logic [5:0]  u_value;
  logic [5:0]  v_value;
  int          errors       = 0;
  int          total_checks = 0;
  int          restarts     = 0;

  spi_host_model spi_host_model_inst (
    .sclk          (sclk),
    .select_line_n (select_line_n),
    .mosi          (mosi)
  );

  video_generator_config_regs video_generator_config_regs_inst (
    .clk                (clk),
    .rstn               (rstn),
    .sclk               (sclk),
    .select_line_n      (select_line_n),
    .mosi               (mosi),
    .chroma_translate   (chroma_translate),
    .protoline          (protoline),
    .line_done          (line_done),
    .sram_word          (sram_word),
    .video_enabled      (video_enabled),
    .video_standard_sel (video_standard_sel),
    .subcarrier_clock   (subcarrier_clock),
    .index_restart      (index_restart),
    .current_line       (current_line),
    .y_value            (y_value),
    .u_value            (u_value),
    .v_value            (v_value)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (index_restart === 1'b1) begin
      restarts <= restarts + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reg_write(input logic [7:0] op, input logic [31:0] d);
    if (op == OP_PROGRAM) begin
      spi_host_model_inst.send({op, d}, 40);
    end else begin
      spi_host_model_inst.send({op, d[15:0], 16'h0000}, 24);
    end
    cycles(30);
  endtask

  function automatic logic [15:0] ctl(input logic en, input logic pal, input logic [3:0] rl,
                                      input logic [9:0] lines);
    return {en, pal, rl, lines};
  endfunction

  task automatic pulse_line;
    @(posedge clk);
    line_done <= 1'b1;
    @(posedge clk);
    line_done <= 1'b0;
    cycles(20);
  endtask

  task automatic check_picks(input logic [5:0] v, input logic [5:0] u, input logic [7:0] y);
    check(32'(v_value), 32'(v), "v pick");
    check(32'(u_value), 32'(u), "u pick");
    check(32'(y_value), 32'(y), "y pick");
  endtask

  task automatic measure_sub(input int lo, input int hi);
    int   n;
    logic last;
    n    = 0;
    @(negedge clk);
    last = subcarrier_clock;
    repeat (4000) begin
      @(negedge clk);
      if (subcarrier_clock === 1'b1 && last === 1'b0) n++;
      last = subcarrier_clock;
    end
    check(32'(n >= lo && n <= hi), 32'h1, "subcarrier rate");
    @(posedge clk);
  endtask

  task automatic test_reset;
    check(32'(video_enabled), 32'h0, "enable at reset");
    check(32'(video_standard_sel), 32'h0, "standard at reset");
    check(32'(current_line), 32'h0, "line at reset");
    check_picks(6'h00, 6'h00, 8'h00);
    $display("test_reset done");
  endtask

  task automatic test_translate;
    logic [15:0] tv;
    logic [15:0] tu;
    reg_write(OP_PROGRAM, 32'hC0B84A0A);
    sram_word        <= 16'h00E6;
    chroma_translate <= 1'b1;
    reg_write(OP_CONTROL_SECOND, 32'(ctl(1'b1, 1'b0, 4'h7, 10'h003)));
    check(32'(video_enabled), 32'h1, "enable");
    check_picks(6'h00, 6'h00, 8'h0E);
    reg_write(OP_V_TABLE, 32'h0000FA52);
    reg_write(OP_U_TABLE, 32'h00004C81);
    for (int idx = 0; idx < 4; idx++) begin
      tv               = 16'hFA52 >> (4 * idx);
      tu               = 16'h4C81 >> (4 * idx);
      sram_word        <= 16'(idx * 5);
      chroma_translate <= 1'b1;
      cycles(30);
      check_picks(6'(tv[3:0]), 6'(tu[3:0]), 8'h00);
      chroma_translate <= 1'b0;
      cycles(30);
      check_picks(6'(idx), 6'(idx), 8'h00);
    end
    $display("test_translate done");
  endtask

  task automatic test_picks;
    reg_write(OP_PROGRAM, 32'hC4BC5C1C);
    sram_word <= 16'hA5C3;
    cycles(30);
    check_picks(6'h03, 6'h0C, 8'hA5);
    measure_sub(285, 288);
    $display("test_picks done");
  endtask

  task automatic test_lines;
    for (int i = 1; i < 4; i++) begin
      pulse_line;
      check(32'(current_line), 32'(i), "line count");
      check(32'(restarts), 32'h0, "early restart");
    end
    pulse_line;
    check(32'(current_line), 32'h0, "line wrap");
    check(32'(restarts), 32'h1, "restart pulse");
    $display("test_lines done");
  endtask

  task automatic test_pal;
    reg_write(OP_CONTROL_SECOND, 32'(ctl(1'b0, 1'b0, 4'h7, 10'h003)));
    check(32'(video_enabled), 32'h0, "disable");
    reg_write(OP_CONTROL_SECOND, 32'(ctl(1'b1, 1'b1, 4'h7, 10'h003)));
    check(32'(video_standard_sel), 32'h1, "pal select");
    check_picks(6'h03, 6'h0C, 8'hA5);
    pulse_line;
    check_picks(6'h3D, 6'h0C, 8'hA5);
    pulse_line;
    check_picks(6'h03, 6'h0C, 8'hA5);
    measure_sub(353, 357);
    $display("test_pal done");
  endtask

  task automatic test_run_length;
    reg_write(OP_CONTROL_SECOND, 32'(ctl(1'b1, 1'b0, 4'h1, 10'h003)));
    sram_word <= 16'h5A3C;
    cycles(30);
    check_picks(6'h0C, 6'h03, 8'hA5);
    protoline <= 1'b1;
    cycles(30);
    check(32'(y_value), 32'h5A, "protoline run");
    protoline <= 1'b0;
    $display("test_run_length done");
  endtask

  task automatic test_refused;
    logic [7:0] ops [3] = '{8'h2D, 8'h2D, 8'h2C};
    int         bits[3] = '{23, 25, 24};
    for (int k = 0; k < 3; k++) begin
      spi_host_model_inst.send({ops[k], 32'h0000_0000}, bits[k]);
      cycles(30);
      check(32'(video_enabled), 32'h1, "bad frame kept out");
    end
    reg_write(OP_CONTROL_SECOND, 32'h0000_0000);
    check(32'(video_enabled), 32'h0, "disable");
    cycles(40);
    check(32'(subcarrier_clock), 32'h0, "subcarrier off");
    $display("test_refused done");
  endtask

  initial begin
    cycles(60000);
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim;
  end

  initial begin
    rstn             = 1'b0;
    sram_word        = 16'h0000;
    chroma_translate = 1'b0;
    protoline        = 1'b0;
    line_done        = 1'b0;
    cycles(8);
    rstn <= 1'b1;
    cycles(4);
    test_reset;
    test_translate;
    test_picks;
    test_lines;
    test_pal;
    test_run_length;
    test_refused;
    end_sim;
  end
endmodule
